// ### src/crv_pkg.sv
// crv_pkg: widths, reset patterns, masks and select codes of the core register bank.
// assumes a single core clock; reset events arrive as synchronous one-cycle pulses.
package crv_pkg;
	localparam int PC_W = 21;
	localparam int SP_FIELD_W = 5;
	// stack pointer layout: full flag, underflow flag, unimplemented bit, pointer field
	localparam int SP_FULL_BIT = 7;
	localparam int SP_UNDER_BIT = 6;
	localparam logic [7:0] SP_IMPL_MASK = 8'hDF;
	localparam logic [SP_FIELD_W-1:0] SP_FIELD_MAX = 5'h1F;
	// interrupt control a: global enables and wake flag field
	localparam int GIE_HIGH_BIT = 7;
	localparam int GIE_LOW_BIT = 6;
	localparam int CTRL_A_FLAG_W = 3;
	localparam int CTRL_C_FLAG_W = 2;
	localparam logic [7:0] CTRL_A_POR = 8'h00;
	localparam logic [7:0] CTRL_A_KEEP_MASK = 8'h01;
	localparam logic [7:0] CTRL_B_POR = 8'hF5;
	localparam logic [7:0] CTRL_B_IMPL_MASK = 8'hF5;
	localparam logic [7:0] CTRL_C_POR = 8'hC0;
	localparam logic [7:0] CTRL_C_IMPL_MASK = 8'hDB;
	localparam logic [7:0] PIR_POR = 8'h00;
	// interrupt vectors taken on an interrupt wake-up
	localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
	localparam logic [PC_W-1:0] VEC_LOW = 21'h000018;
	localparam logic [PC_W-1:0] WAKE_STEP = 21'h000002;
	// widths of the narrow upper bytes, then the full width of file select 0
	localparam int TOS_U_W = 5;
	localparam int PCLAT_U_W = 5;
	localparam int TBL_U_W = 6;
	localparam int FSR_W = 12;
	// first port bit that depends on the oscillator mode
	localparam int PORT_GATED_BIT = 6;
	localparam logic [7:0] PORT_LATCH_POR = 8'h00;
	localparam logic [7:0] PORT_DIR_POR = 8'hFF;
	localparam logic [7:0] DATA_POR = 8'h00;

	// register select for the software access port
	typedef enum logic [4:0] {
		SEL_TOS_U = 5'h00, SEL_TOS_H = 5'h01, SEL_TOS_L = 5'h02, SEL_RETURN_STACK_POINTER = 5'h03,
		SEL_PCLAT_U = 5'h04, SEL_PCLAT_H = 5'h05, SEL_PC_L = 5'h06,
		SEL_TBL_U = 5'h07, SEL_TBL_H = 5'h08, SEL_TBL_L = 5'h09, SEL_TABLE_READ_LATCH = 5'h0A,
		SEL_PROD_H = 5'h0B, SEL_PROD_L = 5'h0C,
		SEL_CTRL_A = 5'h0D, SEL_CTRL_B = 5'h0E, SEL_CTRL_C = 5'h0F, SEL_PIR = 5'h10,
		SEL_FSR0_H = 5'h11, SEL_FSR0_L = 5'h12, SEL_WORKING_REGISTER = 5'h13,
		SEL_INDIRECT = 5'h14,
		SEL_PORT_IN = 5'h15, SEL_PORT_LAT = 5'h16, SEL_PORT_DIR = 5'h17
	} crv_sel_type;
endpackage

// ### src/crv_bit_gate.sv
// crv_bit_gate: forces one bit of a port register to zero unless it exists and is enabled.
// assumes the enable is a level from the oscillator configuration.
`timescale 1ns/1ps
module crv_bit_gate
	import crv_pkg::*;
#(
	parameter int W = 8,
	parameter int GATED_BIT = 6,
	parameter bit PRESENT = 1'b1
)(
	input wire logic [W-1:0] raw_i,
	input wire logic enable_i,
	output logic [W-1:0] gated_o
);
	// absent or disabled bit reads as zero, all others pass untouched
	always_comb
	begin
		gated_o = raw_i;
		gated_o[GATED_BIT] = raw_i[GATED_BIT] & enable_i & PRESENT;
	end
endmodule // crv_bit_gate

// ### src/crv_core_regs.sv
// crv_core_regs: core special registers with power-on, other-reset and wake-up initialisation.
// assumes reset and wake events are one-cycle synchronous pulses from the reset/sleep logic.
// Notes on behaviour
// - power-on or brown-out clears stack, pointers, pc; loads interrupt control patterns.
// - other resets keep both stack flags and ctrl_a bit 0, clear pointer field, else as brown-out.
// - wake-up leaves registers unchanged; program counter moves two bytes past sleep.
// - interrupt wake with a global enable set loads the matching interrupt vector.
// - that wake pushes the program counter plus two to stack top and advances pointer, or sets the full flag when the field is full.
// - interrupt wake needs a flag set; flags are the only interrupt bits changed.
// - first port bit 6 works only in external clock or rc io modes.
// - where bit 6 is absent, reads of it return zero.
`timescale 1ns/1ps
module crv_core_regs
	import crv_pkg::*;
#(
	parameter bit PORT_BIT6_PRESENT = 1'b1
)(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic bor_i,
	input wire logic other_rst_i,
	input wire logic wake_wdt_i,
	input wire logic wake_irq_i,
	input wire logic [CTRL_A_FLAG_W-1:0] wake_flags_a_i,
	input wire logic [CTRL_C_FLAG_W-1:0] wake_flags_c_i,
	input wire logic [7:0] wake_flags_pir_i,
	input wire logic ext_clock_io_osc_mode_i,
	input wire logic ext_rc_io_osc_mode_i,
	input wire logic wr_en_i,
	input wire logic [4:0] wr_sel_i,
	input wire logic [7:0] wr_data_i,
	input wire logic [4:0] rd_sel_i,
	input wire logic [7:0] indirect_data_i,
	input wire logic [7:0] port_pins_i,
	output logic [7:0] rd_data_o,
	output logic [PC_W-1:0] pc_o,
	output logic [FSR_W-1:0] file_select_0_o,
	output logic [7:0] first_port_latch_o,
	output logic [7:0] first_port_direction_o
);
	typedef struct packed {
		logic [PC_W-1:0] tos;
		logic [7:0] return_stack_pointer;
		logic [PCLAT_U_W-1:0] pc_latch_upper;
		logic [7:0] pc_latch_high;
		logic [PC_W-1:0] pc;
		logic [TBL_U_W+15:0] tblptr;
		logic [7:0] table_read_latch;
		logic [15:0] prod;
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic [7:0] ctrl_c;
		logic [7:0] pir;
		logic [FSR_W-1:0] fsr0;
		logic [7:0] working_register;
		logic [7:0] port_lat;
		logic [7:0] port_dir;
		logic [7:0] rd_data;
	} crv_state_type;

	crv_state_type state_q;
	crv_state_type state_d;
	logic bit6_enable;
	logic irq_wake;
	logic any_flag;
	logic [7:0] port_in_g;
	logic [7:0] port_lat_g;
	logic [7:0] port_dir_g;
	logic [PC_W-1:0] pc_next;
	logic [PC_W-1:0] wake_vector;
	logic take_vector;

	// the clock-out pin is free only in the two io oscillator modes
	assign bit6_enable = ext_clock_io_osc_mode_i | ext_rc_io_osc_mode_i;
	assign any_flag = (|wake_flags_a_i) | (|wake_flags_c_i) | (|wake_flags_pir_i);
	// a wake pulse with no flag behind it is ignored, it cannot be an interrupt wake
	assign irq_wake = wake_irq_i & any_flag;
	assign pc_next = PC_W'(state_q.pc + WAKE_STEP);
	assign take_vector = state_q.ctrl_a[GIE_HIGH_BIT] | state_q.ctrl_a[GIE_LOW_BIT];
	// high-priority enable wins when both are set
	assign wake_vector = state_q.ctrl_a[GIE_HIGH_BIT] ? VEC_HIGH : VEC_LOW;

	// the three port registers share one gating cell each
	crv_bit_gate #(.W(8), .GATED_BIT(PORT_GATED_BIT), .PRESENT(PORT_BIT6_PRESENT)) u_gate_in (
		.raw_i(port_pins_i),
		.enable_i(bit6_enable),
		.gated_o(port_in_g)
	);
	crv_bit_gate #(.W(8), .GATED_BIT(PORT_GATED_BIT), .PRESENT(PORT_BIT6_PRESENT)) u_gate_lat (
		.raw_i(state_q.port_lat),
		.enable_i(bit6_enable),
		.gated_o(port_lat_g)
	);
	crv_bit_gate #(.W(8), .GATED_BIT(PORT_GATED_BIT), .PRESENT(PORT_BIT6_PRESENT)) u_gate_dir (
		.raw_i(state_q.port_dir),
		.enable_i(bit6_enable),
		.gated_o(port_dir_g)
	);

	// next state: brown-out first, then other resets, then wake-up, then software writes
	always_comb
	begin
		state_d = state_q;
		if (bor_i)
		begin
			state_d.tos = '0;
			state_d.return_stack_pointer = '0;
			state_d.pc_latch_upper = '0;
			state_d.pc_latch_high = '0;
			state_d.pc = '0;
			state_d.tblptr = '0;
			state_d.table_read_latch = '0;
			state_d.ctrl_a = CTRL_A_POR;
			state_d.ctrl_b = CTRL_B_POR;
			state_d.ctrl_c = CTRL_C_POR;
			state_d.pir = PIR_POR;
		end
		else if (other_rst_i)
		begin
			state_d.tos = '0;
			// stack flags survive so software can see why it restarted
			state_d.return_stack_pointer = state_q.return_stack_pointer & 8'hC0;
			state_d.pc_latch_upper = '0;
			state_d.pc_latch_high = '0;
			state_d.pc = '0;
			state_d.tblptr = '0;
			state_d.table_read_latch = '0;
			state_d.ctrl_a = (state_q.ctrl_a & CTRL_A_KEEP_MASK) | CTRL_A_POR;
			state_d.ctrl_b = CTRL_B_POR;
			state_d.ctrl_c = CTRL_C_POR;
			state_d.pir = PIR_POR;
		end
		else if (irq_wake)
		begin
			// only flag bits move; enables and edges stay as software left them
			state_d.ctrl_a[CTRL_A_FLAG_W-1:0] = state_q.ctrl_a[CTRL_A_FLAG_W-1:0] | wake_flags_a_i;
			state_d.ctrl_c[CTRL_C_FLAG_W-1:0] = state_q.ctrl_c[CTRL_C_FLAG_W-1:0] | wake_flags_c_i;
			state_d.pir = state_q.pir | wake_flags_pir_i;
			if (take_vector)
			begin
				state_d.pc = wake_vector;
				state_d.tos = pc_next;
				// a full stack sets the full flag instead of wrapping the pointer
				if (state_q.return_stack_pointer[SP_FIELD_W-1:0] == SP_FIELD_MAX)
					state_d.return_stack_pointer[SP_FULL_BIT] = 1'b1;
				else
					state_d.return_stack_pointer[SP_FIELD_W-1:0] = SP_FIELD_W'(state_q.return_stack_pointer[SP_FIELD_W-1:0] + 5'h01);
			end
			else
				state_d.pc = pc_next;
		end
		else if (wake_wdt_i)
			state_d.pc = pc_next;
		else if (wr_en_i)
		begin
			case (wr_sel_i)
				SEL_TOS_U: state_d.tos[PC_W-1:16] = wr_data_i[TOS_U_W-1:0];
				SEL_TOS_H: state_d.tos[15:8] = wr_data_i;
				SEL_TOS_L: state_d.tos[7:0] = wr_data_i;
				SEL_RETURN_STACK_POINTER: state_d.return_stack_pointer = wr_data_i & SP_IMPL_MASK;
				SEL_PCLAT_U: state_d.pc_latch_upper = wr_data_i[PCLAT_U_W-1:0];
				SEL_PCLAT_H: state_d.pc_latch_high = wr_data_i;
				// writing the low byte jumps, taking the upper bytes from the latches
				SEL_PC_L: state_d.pc = {state_q.pc_latch_upper, state_q.pc_latch_high, wr_data_i};
				SEL_TBL_U: state_d.tblptr[TBL_U_W+15:16] = wr_data_i[TBL_U_W-1:0];
				SEL_TBL_H: state_d.tblptr[15:8] = wr_data_i;
				SEL_TBL_L: state_d.tblptr[7:0] = wr_data_i;
				SEL_TABLE_READ_LATCH: state_d.table_read_latch = wr_data_i;
				SEL_PROD_H: state_d.prod[15:8] = wr_data_i;
				SEL_PROD_L: state_d.prod[7:0] = wr_data_i;
				SEL_CTRL_A: state_d.ctrl_a = wr_data_i;
				SEL_CTRL_B: state_d.ctrl_b = wr_data_i & CTRL_B_IMPL_MASK;
				SEL_CTRL_C: state_d.ctrl_c = wr_data_i & CTRL_C_IMPL_MASK;
				SEL_PIR: state_d.pir = wr_data_i;
				SEL_FSR0_H: state_d.fsr0[FSR_W-1:8] = wr_data_i[3:0];
				SEL_FSR0_L: state_d.fsr0[7:0] = wr_data_i;
				SEL_WORKING_REGISTER: state_d.working_register = wr_data_i;
				SEL_PORT_LAT: state_d.port_lat = wr_data_i;
				SEL_PORT_DIR: state_d.port_dir = wr_data_i;
				default: state_d.working_register = state_q.working_register; // indirect and port input hold nothing
			endcase
		end
		// read data is registered; indirect reads pass the addressed byte straight on
		case (rd_sel_i)
			SEL_TOS_U: state_d.rd_data = 8'(state_q.tos[PC_W-1:16]);
			SEL_TOS_H: state_d.rd_data = state_q.tos[15:8];
			SEL_TOS_L: state_d.rd_data = state_q.tos[7:0];
			SEL_RETURN_STACK_POINTER: state_d.rd_data = state_q.return_stack_pointer;
			SEL_PCLAT_U: state_d.rd_data = 8'(state_q.pc_latch_upper);
			SEL_PCLAT_H: state_d.rd_data = state_q.pc_latch_high;
			SEL_PC_L: state_d.rd_data = state_q.pc[7:0];
			SEL_TBL_U: state_d.rd_data = 8'(state_q.tblptr[TBL_U_W+15:16]);
			SEL_TBL_H: state_d.rd_data = state_q.tblptr[15:8];
			SEL_TBL_L: state_d.rd_data = state_q.tblptr[7:0];
			SEL_TABLE_READ_LATCH: state_d.rd_data = state_q.table_read_latch;
			SEL_PROD_H: state_d.rd_data = state_q.prod[15:8];
			SEL_PROD_L: state_d.rd_data = state_q.prod[7:0];
			SEL_CTRL_A: state_d.rd_data = state_q.ctrl_a;
			SEL_CTRL_B: state_d.rd_data = state_q.ctrl_b;
			SEL_CTRL_C: state_d.rd_data = state_q.ctrl_c;
			SEL_PIR: state_d.rd_data = state_q.pir;
			SEL_FSR0_H: state_d.rd_data = 8'(state_q.fsr0[FSR_W-1:8]);
			SEL_FSR0_L: state_d.rd_data = state_q.fsr0[7:0];
			SEL_WORKING_REGISTER: state_d.rd_data = state_q.working_register;
			SEL_INDIRECT: state_d.rd_data = indirect_data_i;
			SEL_PORT_IN: state_d.rd_data = port_in_g;
			SEL_PORT_LAT: state_d.rd_data = port_lat_g;
			SEL_PORT_DIR: state_d.rd_data = port_dir_g;
			default: state_d.rd_data = 8'h00;
		endcase
	end

	// power-on reset loads the same patterns as a brown-out
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_q <= '0;
			state_q.ctrl_a <= CTRL_A_POR;
			state_q.ctrl_b <= CTRL_B_POR;
			state_q.ctrl_c <= CTRL_C_POR;
			state_q.port_lat <= PORT_LATCH_POR;
			state_q.port_dir <= PORT_DIR_POR;
			state_q.rd_data <= DATA_POR;
		end
		else
			state_q <= state_d;
	end

	assign rd_data_o = state_q.rd_data;
	assign pc_o = state_q.pc;
	assign file_select_0_o = state_q.fsr0;
	assign first_port_latch_o = port_lat_g;
	assign first_port_direction_o = port_dir_g;

	sequence s_vec_wake;
		!bor_i && !other_rst_i && irq_wake && take_vector;
	endsequence
	// an interrupt wake outranks a watchdog wake in the same cycle, so only an unvectored one counts here
	sequence s_plain_wake;
		!bor_i && !other_rst_i && ((wake_wdt_i && !irq_wake) || (irq_wake && !take_vector));
	endsequence

	property p_bor_init;
		@(posedge clk_i) disable iff (!rst_b_i)
		bor_i |=> (state_q.pc == '0) && (state_q.tos == '0) && (state_q.return_stack_pointer == 8'h00)
			&& (state_q.ctrl_b == CTRL_B_POR) && (state_q.ctrl_c == CTRL_C_POR) && (state_q.tblptr == '0);
	endproperty
	a_bor_init: assert property (p_bor_init) else $error("brown-out init wrong");

	property p_other_rst;
		@(posedge clk_i) disable iff (!rst_b_i)
		(other_rst_i && !bor_i) |=> (state_q.return_stack_pointer[7:6] == $past(state_q.return_stack_pointer[7:6]))
			&& (state_q.return_stack_pointer[4:0] == 5'h00) && (state_q.pc == '0) && (state_q.ctrl_b == CTRL_B_POR);
	endproperty
	a_other_rst: assert property (p_other_rst) else $error("other reset stack flags lost");

	property p_plain_wake;
		@(posedge clk_i) disable iff (!rst_b_i)
		s_plain_wake |=> (state_q.pc == PC_W'($past(state_q.pc) + WAKE_STEP))
			&& $stable(state_q.tos) && $stable(state_q.tblptr) && $stable(state_q.working_register);
	endproperty
	a_plain_wake: assert property (p_plain_wake) else $error("wake pc not advanced by two");

	property p_vec_high;
		@(posedge clk_i) disable iff (!rst_b_i)
		(s_vec_wake and state_q.ctrl_a[GIE_HIGH_BIT]) |=> (state_q.pc == VEC_HIGH);
	endproperty
	a_vec_high: assert property (p_vec_high) else $error("high vector not taken");

	property p_vec_low;
		@(posedge clk_i) disable iff (!rst_b_i)
		(s_vec_wake and !state_q.ctrl_a[GIE_HIGH_BIT]) |=> (state_q.pc == VEC_LOW);
	endproperty
	a_vec_low: assert property (p_vec_low) else $error("low vector not taken");

	property p_push;
		@(posedge clk_i) disable iff (!rst_b_i)
		(s_vec_wake and (state_q.return_stack_pointer[4:0] != SP_FIELD_MAX)) |=>
			(state_q.tos == PC_W'($past(state_q.pc) + WAKE_STEP))
			&& (state_q.return_stack_pointer[4:0] == 5'($past(state_q.return_stack_pointer[4:0]) + 5'h01));
	endproperty
	a_push: assert property (p_push) else $error("stack push wrong on wake");

	property p_flags_only;
		@(posedge clk_i) disable iff (!rst_b_i)
		(!bor_i && !other_rst_i && irq_wake) |=> $stable(state_q.ctrl_b)
			&& (state_q.ctrl_a[7:3] == $past(state_q.ctrl_a[7:3])) && (state_q.ctrl_c[7:2] == $past(state_q.ctrl_c[7:2]))
			&& ((state_q.pir & $past(wake_flags_pir_i)) == $past(wake_flags_pir_i));
	endproperty
	a_flags_only: assert property (p_flags_only) else $error("wake changed non-flag bits");

	property p_bit6_mode;
		@(posedge clk_i) disable iff (!rst_b_i)
		(!bit6_enable && (rd_sel_i inside {SEL_PORT_IN, SEL_PORT_LAT, SEL_PORT_DIR})) |=> !rd_data_o[PORT_GATED_BIT];
	endproperty
	a_bit6_mode: assert property (p_bit6_mode) else $error("port bit 6 visible in wrong mode");

	property p_bit6_absent;
		@(posedge clk_i) disable iff (!rst_b_i)
		(!PORT_BIT6_PRESENT && (rd_sel_i == SEL_PORT_IN)) |=> !rd_data_o[PORT_GATED_BIT];
	endproperty
	a_bit6_absent: assert property (p_bit6_absent) else $error("absent port bit 6 read as one");

	property p_indirect;
		@(posedge clk_i) disable iff (!rst_b_i)
		(rd_sel_i == SEL_INDIRECT) |=> (rd_data_o == $past(indirect_data_i));
	endproperty
	a_indirect: assert property (p_indirect) else $error("indirect read not passed through");
endmodule // crv_core_regs

// ### verification/crv_core_regs_tb_top.sv
// crv_core_regs_tb_top: self-checking bench for the core register bank, reset, wake and port gating.
// assumes crv_pkg is compiled first; the bench drives every port itself at the rising edge.
`timescale 1ns/1ps
module crv_core_regs_tb_top
	import crv_pkg::*;
;
	typedef struct {int kind; logic [31:0] exp; string name;} crv_note_type;
	logic clk = 1'b0, rst_b = 1'b0, pend = 1'b0, seen_v = 1'b0, wr_en = 1'b0, m_ec = 1'b0, m_rc = 1'b0;
	logic [3:0] evt = 4'h0;
	logic [2:0] fa = 3'h0;
	logic [1:0] fc = 2'h0;
	logic [7:0] fp = 8'h00, wr_data = 8'h00, ind_data = 8'h00, pins = 8'h00;
	logic [4:0] wr_sel = 5'h00, rd_sel = 5'h00;
	logic [7:0] rd_data, lat, dir, lat2, dir2;
	logic [PC_W-1:0] pc;
	logic [FSR_W-1:0] fsr;
	integer seed = 32'h43a2;
	int fails = 0, checks_done = 0;
	crv_note_type notes [$];
	crv_note_type cur;
	logic [4:0] ws [10] = '{SEL_TOS_H, SEL_TOS_L, SEL_PCLAT_H, SEL_TBL_H, SEL_TBL_L, SEL_TABLE_READ_LATCH,
		SEL_PROD_H, SEL_PROD_L, SEL_FSR0_L, SEL_WORKING_REGISTER};
	logic [7:0] wv [10];
	logic [7:0] ctls [4] = '{8'h80, 8'h40, 8'hC0, 8'h00};
	logic [PC_W-1:0] p, tos, pcv;
	logic [4:0] sp;
	logic [7:0] ctl, cc, pr, f, wv0, msk;
	logic [1:0] c;

	// main instance with bit 6 present, second one models a variant without it
	crv_core_regs dut (.clk_i(clk), .rst_b_i(rst_b), .bor_i(evt[0]), .other_rst_i(evt[1]), .wake_wdt_i(evt[2]),
		.wake_irq_i(evt[3]), .wake_flags_a_i(fa), .wake_flags_c_i(fc), .wake_flags_pir_i(fp),
		.ext_clock_io_osc_mode_i(m_ec), .ext_rc_io_osc_mode_i(m_rc), .wr_en_i(wr_en), .wr_sel_i(wr_sel),
		.wr_data_i(wr_data), .rd_sel_i(rd_sel), .indirect_data_i(ind_data), .port_pins_i(pins),
		.rd_data_o(rd_data), .pc_o(pc), .file_select_0_o(fsr), .first_port_latch_o(lat), .first_port_direction_o(dir));
	crv_core_regs #(.PORT_BIT6_PRESENT(1'b0)) dut_nb6 (.clk_i(clk), .rst_b_i(rst_b), .bor_i(evt[0]),
		.other_rst_i(evt[1]), .wake_wdt_i(evt[2]), .wake_irq_i(evt[3]), .wake_flags_a_i(fa), .wake_flags_c_i(fc),
		.wake_flags_pir_i(fp), .ext_clock_io_osc_mode_i(m_ec), .ext_rc_io_osc_mode_i(m_rc), .wr_en_i(wr_en),
		.wr_sel_i(wr_sel), .wr_data_i(wr_data), .rd_sel_i(rd_sel), .indirect_data_i(ind_data), .port_pins_i(pins),
		.rd_data_o(), .pc_o(), .file_select_0_o(), .first_port_latch_o(lat2), .first_port_direction_o(dir2));

	// 100 mhz core clock
	always #5 clk = ~clk;

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// the expectation is queued with the request; read data lands one cycle later
	task automatic look(input int k, input logic [4:0] s, input logic [31:0] e, input string n);
		@(posedge clk);
		rd_sel <= s;
		pend <= 1'b1;
		notes.push_back('{k, e, n});
		@(posedge clk);
		pend <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] s, input logic [31:0] e, input string n);
		look(0, s, e, n);
	endtask

	task automatic wr(input logic [4:0] s, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		wr_sel <= s;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task automatic ev(input logic [3:0] v);
		@(posedge clk);
		evt <= v;
		@(posedge clk);
		evt <= 4'h0;
	endtask

	task automatic irq(input logic [2:0] a, input logic [1:0] cf, input logic [7:0] pf);
		@(posedge clk);
		evt <= 4'h8;
		fa <= a;
		fc <= cf;
		fp <= pf;
		@(posedge clk);
		evt <= 4'h0;
		fa <= 3'h0;
		fc <= 2'h0;
		fp <= 8'h00;
	endtask

	function automatic logic [7:0] por_val(input int s);
		case (s)
			SEL_CTRL_B: return CTRL_B_POR;
			SEL_CTRL_C: return CTRL_C_POR;
			SEL_PORT_DIR: return PORT_DIR_POR & ~(8'h01 << PORT_GATED_BIT);
			default: return 8'h00;
		endcase
	endfunction

	// monitor: sampled at the falling edge, after the capturing edge has settled
	always @(posedge clk) seen_v <= pend;
	always @(negedge clk)
	begin
		if (seen_v === 1'b1 && notes.size() > 0)
		begin
			cur = notes.pop_front();
			case (cur.kind)
				0: check(cur.name, {24'h0, rd_data}, cur.exp);
				1: check(cur.name, {11'h0, pc}, cur.exp);
				2: check(cur.name, {24'h0, lat}, cur.exp);
				3: check(cur.name, {24'h0, dir}, cur.exp);
				4: check(cur.name, {24'h0, lat2}, cur.exp);
				5: check(cur.name, {24'h0, dir2}, cur.exp);
				default: check(cur.name, {20'h0, fsr}, cur.exp);
			endcase
		end
	end

	// watchdog: the sequence needs well under 10k cycles
	initial
	begin
		#200us;
		fails++;
		final_report();
	end

	initial
	begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		for (int s = 0; s < 24; s++) if (s != 20 && s != 21) rd(5'(s), por_val(s), "por_read");
		look(1, 5'h00, 0, "por_pc");
		// fill, then other reset keeps only the undefined-at-power-on group
		foreach (ws[i])
		begin
			wv[i] = 8'($random(seed));
			wr(ws[i], wv[i]);
			rd(ws[i], wv[i], "readback");
		end
		ev(4'h2);
		foreach (ws[i]) rd(ws[i], (ws[i] inside {SEL_PROD_H, SEL_PROD_L, SEL_FSR0_L, SEL_WORKING_REGISTER}) ? wv[i] : 8'h00, "other_rst");
		look(6, 5'h00, {24'h0, wv[8]}, "fsr_out");
		// brown-out leaves the unknown-at-power-on group (product, file select, working) as it was
		ev(4'h1);
		foreach (ws[i]) rd(ws[i], (ws[i] inside {SEL_PROD_H, SEL_PROD_L, SEL_FSR0_L, SEL_WORKING_REGISTER}) ? wv[i] : 8'h00, "bor_clear");
		// interrupt wake under each combination of global enables
		sp = 5'h00;
		tos = '0;
		cc = CTRL_C_POR;
		pr = PIR_POR;
		for (int i = 0; i < 4; i++)
		begin
			ctl = ctls[i];
			p = {5'($random(seed)), 16'($random(seed))};
			wr(SEL_PCLAT_U, {3'h0, p[20:16]});
			wr(SEL_PCLAT_H, p[15:8]);
			wr(SEL_PC_L, p[7:0]);
			wr(SEL_CTRL_A, ctl);
			c = 2'($random(seed));
			f = 8'($random(seed));
			irq(3'h1, c, f);
			cc = cc | {6'h00, c};
			pr = pr | f;
			if (ctl[7:6] != 2'b00)
			begin
				tos = p + WAKE_STEP;
				sp = sp + 5'h01;
				pcv = ctl[7] ? VEC_HIGH : VEC_LOW;
			end
			else
				pcv = p + WAKE_STEP;
			look(1, 5'h00, pcv, "wake_pc");
			rd(SEL_TOS_U, {3'h0, tos[20:16]}, "tos_u");
			rd(SEL_TOS_H, tos[15:8], "tos_h");
			rd(SEL_TOS_L, tos[7:0], "tos_l");
			rd(SEL_RETURN_STACK_POINTER, {3'h0, sp}, "return_stack_pointer");
			rd(SEL_CTRL_A, ctl | 8'h01, "ctrl_a");
		end
		rd(SEL_CTRL_C, cc, "ctrl_c");
		rd(SEL_PIR, pr, "pir");
		irq(3'h0, 2'h0, 8'h00);
		look(1, 5'h00, pcv, "no_flag_wake");
		// watchdog wake with a colliding write: the write is dropped
		wv0 = 8'($random(seed));
		wr(SEL_WORKING_REGISTER, wv0);
		@(posedge clk);
		evt <= 4'h4;
		wr_en <= 1'b1;
		wr_sel <= SEL_WORKING_REGISTER;
		wr_data <= ~wv0;
		@(posedge clk);
		evt <= 4'h0;
		wr_en <= 1'b0;
		pcv = pcv + WAKE_STEP;
		look(1, 5'h00, pcv, "wdt_pc");
		rd(SEL_WORKING_REGISTER, wv0, "wdt_working_register");
		rd(SEL_TOS_L, tos[7:0], "wdt_tos");
		// saturate the pointer field, then other reset keeps the flags
		ev(4'h1);
		wr(SEL_CTRL_A, 8'h80);
		repeat (32) irq(3'h1, 2'h0, 8'h00);
		rd(SEL_RETURN_STACK_POINTER, 8'h9F, "stk_full");
		ev(4'h2);
		rd(SEL_RETURN_STACK_POINTER, 8'h80, "stk_keep");
		rd(SEL_CTRL_A, 8'h01, "ctrl_a_keep");
		ev(4'h1);
		rd(SEL_RETURN_STACK_POINTER, 8'h00, "stk_bor");
		// port bit 6 in each oscillator mode, on both variants
		wr(SEL_PORT_LAT, 8'hFF);
		for (int m = 0; m < 4; m++)
		begin
			@(posedge clk);
			m_ec <= m[0];
			m_rc <= m[1];
			pins <= 8'($random(seed)) | 8'h40;
			@(posedge clk);
			msk = (m != 0) ? 8'hFF : 8'hBF;
			look(2, 5'h00, msk, "latch_out");
			look(3, 5'h00, msk, "dir_out");
			rd(SEL_PORT_IN, pins & msk, "port_in");
			look(4, 5'h00, 8'hBF, "latch_nb6");
			look(5, 5'h00, 8'hBF, "dir_nb6");
		end
		// indirect reads follow the addressed byte, writes store nothing
		// the expected byte is kept in a blocking copy, the driven one only lands after this time step
		f = 8'($random(seed));
		ind_data <= f;
		rd(SEL_INDIRECT, f, "indirect");
		wr(SEL_INDIRECT, ~f);
		f = 8'($random(seed));
		ind_data <= f;
		rd(SEL_INDIRECT, f, "indirect_nw");
		rd(SEL_WORKING_REGISTER, wv0, "indirect_nw_working_register");
		rd(5'h1F, 8'h00, "unmapped");
		repeat (4) @(posedge clk);
		final_report();
	end
endmodule // crv_core_regs_tb_top
